/* shared/pin_mode_pkg.sv */
// shared constants for the shared pin mode select block
package pin_mode_pkg;
    localparam int          BIT_TIME_CYCLES = 16;
    localparam int          DBG_CNT_W       = 4;
    localparam int          SPEEDUP_CYCLES  = 1;
    localparam logic        MODE_RUN        = 1'b0;
    localparam logic        MODE_BACKGROUND = 1'b1;
    localparam logic [1:0]  FUNC_PORT       = 2'h0;
    localparam logic [1:0]  FUNC_INTERRUPT  = 2'h1;
    localparam logic [1:0]  FUNC_TIMER_CLK  = 2'h2;
    localparam logic [1:0]  FUNC_RESET      = 2'h3;
    localparam int          SYNC_STAGES     = 2;
endpackage

/* src/pin_sync.sv */
// two-flop synchroniser for an asynchronous pin level
module pin_sync
    import pin_mode_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    logic meta;
    logic next_meta;
    logic next_q;

    always_comb begin
        next_meta = d_i;
        next_q    = meta;
    end

    // idles high: the pin pulls up when nobody drives it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta <= 1'b1;
            q_o  <= 1'b1;
        end else begin
            meta <= next_meta;
            q_o  <= next_q;
        end
    end
endmodule // pin_sync

/* src/bit_timer.sv */
// debug bit-time counter, one pulse per bit
module bit_timer
    import pin_mode_pkg::*;
#(
    parameter int CYCLES = BIT_TIME_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic run_i,
    input  wire logic dbg_tick_i,
    output logic      bit_end_o,
    output logic      first_o
);
    localparam int W = $clog2(CYCLES);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    always_comb begin
        next_count = count;
        if (!run_i) begin
            next_count = '0;
        end else if (dbg_tick_i) begin
            next_count = (count == W'(CYCLES - 1)) ? '0 : count + W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign bit_end_o = run_i && dbg_tick_i && (count == W'(CYCLES - 1));
    assign first_o   = run_i && (count == '0);
endmodule // bit_timer

/* src/shared_pin_mode_select.sv */
// function selection and reset-time behaviour of the two shared pins
module shared_pin_mode_select
    import pin_mode_pkg::*;
(
    input  wire logic       REF_CLK_I,
    input  wire logic       RST_I,
    input  wire logic       POR_I,
    input  wire logic       FORCE_RESET_I,
    input  wire logic       OTHER_RESET_I,
    input  wire logic [1:0] FUNC_SEL_I,
    input  wire logic       FUNC_SEL_WE_I,
    input  wire logic       DEBUG_PIN_ENABLE_CLR_I,
    input  wire logic       PORT_A_BIT4_OUT_I,
    input  wire logic       DBG_TICK_I,
    input  wire logic       DBG_TX_ACTIVE_I,
    input  wire logic       DBG_TX_BIT_I,
    input  wire logic       SHARED_PIN_I,
    input  wire logic       BACKGROUND_DEBUG_PIN_I,
    output logic            BACKGROUND_DEBUG_PIN_O,
    output logic            BACKGROUND_DEBUG_PIN_OE_O,
    output logic            BACKGROUND_DEBUG_PULLUP_O,
    output logic            SHARED_PIN_OE_O,
    output logic            SHARED_PIN_PULLUP_O,
    output logic            EXT_RESET_REQ_O,
    output logic            IRQ_IN_O,
    output logic            BRANCH_INT_PIN_LEVEL_O,
    output logic            EXT_TIMER_CLOCK_IN_O,
    output logic            PORT_A_BIT5_INPUT_O,
    output logic [1:0]      FUNC_SEL_O,
    output logic            DEBUG_PIN_ENABLE_O,
    output logic            MODE_O,
    output logic            MODE_SELECT_PHASE_O,
    output logic            DBG_RX_BIT_O,
    output logic            DBG_RX_VALID_O
);
    typedef enum logic [2:0] {
        ST_IN_RESET = 3'b001,
        ST_SAMPLE   = 3'b010,
        ST_RUNNING  = 3'b100
    } phase_t;

    phase_t     phase;
    phase_t     next_phase;
    logic [1:0] func_sel;
    logic [1:0] next_func_sel;
    logic       debug_pin_enable;
    logic       next_debug_pin_enable;
    logic       mode;
    logic       next_mode;
    logic       mode_reset;
    logic       next_mode_reset;
    logic       shared_s;
    logic       dbg_s;
    logic       dbg_prev;
    logic       next_dbg_prev;
    logic       rx_run;
    logic       next_rx_run;
    logic       rx_bit;
    logic       next_rx_bit;
    logic       rx_valid;
    logic       next_rx_valid;
    logic       speedup;
    logic       next_speedup;
    logic       tx_prev;
    logic       next_tx_prev;
    logic       bit_end;
    logic       bit_first;
    logic       any_reset;
    logic       dbg_link_on;

    pin_sync u_shared_sync (
        .clk_i (REF_CLK_I),
        .rst_i (RST_I),
        .d_i   (SHARED_PIN_I),
        .q_o   (shared_s)
    );

    pin_sync u_dbg_sync (
        .clk_i (REF_CLK_I),
        .rst_i (RST_I),
        .d_i   (BACKGROUND_DEBUG_PIN_I),
        .q_o   (dbg_s)
    );

    bit_timer #(
        .CYCLES (BIT_TIME_CYCLES)
    ) u_bit_timer (
        .clk_i      (REF_CLK_I),
        .rst_i      (RST_I),
        .run_i      (rx_run),
        .dbg_tick_i (DBG_TICK_I),
        .bit_end_o  (bit_end),
        .first_o    (bit_first)
    );

    // pin-driven reset counts only while the function is selected
    // a stale synced low can trip one reset when this function is first picked
    assign EXT_RESET_REQ_O = (func_sel == FUNC_RESET) && !shared_s;
    assign any_reset       = POR_I || FORCE_RESET_I || OTHER_RESET_I || EXT_RESET_REQ_O;
    assign dbg_link_on     = (phase == ST_RUNNING) && debug_pin_enable;

    // function selection survives every reset except power-on
    always_comb begin
        next_func_sel = func_sel;
        if (POR_I) begin
            next_func_sel = FUNC_PORT;
        end else if (FUNC_SEL_WE_I && !any_reset) begin
            // writes during any reset are refused
            next_func_sel = FUNC_SEL_I;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            func_sel <= FUNC_PORT;
        end else begin
            func_sel <= next_func_sel;
        end
    end

    // a reset in the same cycle as a clear wins
    always_comb begin
        next_debug_pin_enable = debug_pin_enable;
        if (any_reset) begin
            next_debug_pin_enable = 1'b1;
        end else if (DEBUG_PIN_ENABLE_CLR_I) begin
            // software clears it to hand the pin to the port
            next_debug_pin_enable = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            debug_pin_enable <= 1'b1;
        end else begin
            debug_pin_enable <= next_debug_pin_enable;
        end
    end

    // flag keeps the kind of the last reset until the sample cycle
    always_comb begin
        next_mode       = mode;
        next_mode_reset = mode_reset;
        if (POR_I || FORCE_RESET_I) begin
            next_mode_reset = 1'b1;
        end else if (OTHER_RESET_I || EXT_RESET_REQ_O) begin
            next_mode_reset = 1'b0;
        end
        if (phase == ST_SAMPLE) begin
            // sampled at the rising edge of internal reset
            next_mode = (mode_reset && !dbg_s) ? MODE_BACKGROUND : MODE_RUN;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            mode       <= MODE_RUN;
            mode_reset <= 1'b1;
        end else begin
            mode       <= next_mode;
            mode_reset <= next_mode_reset;
        end
    end

    // any reset source holds the pin in its mode-select role
    always_comb begin
        next_phase = phase;
        unique case (phase)
            ST_IN_RESET: begin
                if (!any_reset) begin
                    next_phase = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                // one cycle in which the synced pin is read as mode select
                next_phase = ST_RUNNING;
            end
            ST_RUNNING: begin
                if (any_reset) begin
                    next_phase = ST_IN_RESET;
                end
            end
        endcase
        if (any_reset) begin
            next_phase = ST_IN_RESET;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            phase <= ST_IN_RESET;
        end else begin
            phase <= next_phase;
        end
    end

    // debug link receive: a falling edge opens one bit cell
    always_comb begin
        next_dbg_prev = dbg_s;
        next_rx_run   = rx_run;
        next_rx_bit   = rx_bit;
        next_rx_valid = 1'b0;
        if (!dbg_link_on) begin
            next_rx_run = 1'b0;
        end else if (!rx_run && dbg_prev && !dbg_s && !DBG_TX_ACTIVE_I) begin
            next_rx_run = 1'b1; // falling edge starts a bit
        end else if (rx_run) begin
            if (bit_first && DBG_TICK_I) begin
                next_rx_bit = 1'b0;
            end
            if (bit_end) begin
                next_rx_bit   = dbg_s; // late sample of the bit cell
                next_rx_valid = 1'b1;
                next_rx_run   = 1'b0;
            end
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            dbg_prev <= 1'b1;
            rx_run   <= 1'b0;
            rx_bit   <= 1'b0;
            rx_valid <= 1'b0;
        end else begin
            dbg_prev <= next_dbg_prev;
            rx_run   <= next_rx_run;
            rx_bit   <= next_rx_bit;
            rx_valid <= next_rx_valid;
        end
    end

    // brief high drive when released from a driven low
    always_comb begin
        next_tx_prev = DBG_TX_ACTIVE_I && DBG_TX_BIT_I;
        next_speedup = 1'b0;
        if (dbg_link_on && DBG_TX_ACTIVE_I && DBG_TX_BIT_I && !tx_prev) begin
            next_speedup = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            speedup <= 1'b0;
            tx_prev <= 1'b0;
        end else begin
            speedup <= next_speedup;
            tx_prev <= next_tx_prev;
        end
    end

    // shared input pin: never driven, whatever function is selected
    assign SHARED_PIN_OE_O        = 1'b0;
    assign SHARED_PIN_PULLUP_O    = (func_sel == FUNC_RESET);
    assign IRQ_IN_O               = (func_sel == FUNC_INTERRUPT) ? shared_s : 1'b1;
    assign BRANCH_INT_PIN_LEVEL_O = (func_sel == FUNC_INTERRUPT) ? shared_s : 1'b1;
    assign EXT_TIMER_CLOCK_IN_O   = (func_sel == FUNC_TIMER_CLK) && shared_s;
    assign PORT_A_BIT5_INPUT_O    = (func_sel == FUNC_PORT) && shared_s;

    // debug pin: pseudo open drain, driven low or pulsed high; drives PORT_A_BIT4_OUT_I when running with the link off
    always_comb begin
        BACKGROUND_DEBUG_PIN_O    = 1'b0;
        BACKGROUND_DEBUG_PIN_OE_O = 1'b0;
        BACKGROUND_DEBUG_PULLUP_O = 1'b1;
        if (phase != ST_RUNNING) begin
            BACKGROUND_DEBUG_PIN_OE_O = 1'b0;
        end else if (dbg_link_on) begin
            if (DBG_TX_ACTIVE_I && !DBG_TX_BIT_I) begin
                BACKGROUND_DEBUG_PIN_OE_O = 1'b1;
            end else if (speedup) begin
                BACKGROUND_DEBUG_PIN_O    = 1'b1;
                BACKGROUND_DEBUG_PIN_OE_O = 1'b1;
            end
        end else begin
            BACKGROUND_DEBUG_PULLUP_O = 1'b0;
            BACKGROUND_DEBUG_PIN_O    = PORT_A_BIT4_OUT_I;
            BACKGROUND_DEBUG_PIN_OE_O = 1'b1;
        end
    end

    assign FUNC_SEL_O          = func_sel;
    assign DEBUG_PIN_ENABLE_O  = debug_pin_enable;
    assign MODE_O              = mode;
    assign MODE_SELECT_PHASE_O = (phase != ST_RUNNING);
    assign DBG_RX_BIT_O        = rx_bit;
    assign DBG_RX_VALID_O      = rx_valid;
endmodule // shared_pin_mode_select

/* verification/shared_pin_mode_select_monitor.sv */
// concurrent checks on the ports of the shared pin mode select block
module shared_pin_mode_select_monitor
    import pin_mode_pkg::*;
(
    input wire logic       REF_CLK_I,
    input wire logic       RST_I,
    input wire logic       POR_I,
    input wire logic       FORCE_RESET_I,
    input wire logic       OTHER_RESET_I,
    input wire logic       SHARED_PIN_I,
    input wire logic       SHARED_PIN_OE_O,
    input wire logic       SHARED_PIN_PULLUP_O,
    input wire logic       EXT_RESET_REQ_O,
    input wire logic       IRQ_IN_O,
    input wire logic       BRANCH_INT_PIN_LEVEL_O,
    input wire logic       EXT_TIMER_CLOCK_IN_O,
    input wire logic [1:0] FUNC_SEL_O,
    input wire logic       DEBUG_PIN_ENABLE_O,
    input wire logic       MODE_SELECT_PHASE_O,
    input wire logic       DBG_RX_VALID_O,
    input wire logic       BACKGROUND_DEBUG_PIN_O,
    input wire logic       BACKGROUND_DEBUG_PIN_OE_O
);
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (RST_I);
    wire any_rst = POR_I | FORCE_RESET_I | OTHER_RESET_I;
    wire hi_drv = BACKGROUND_DEBUG_PIN_OE_O & BACKGROUND_DEBUG_PIN_O;
    property p_no_drive; !SHARED_PIN_OE_O; endproperty
    a_no_drive: assert property (p_no_drive) else $error("shared pin driven");
    property p_pullup; FUNC_SEL_O == FUNC_RESET |-> SHARED_PIN_PULLUP_O; endproperty
    a_pullup: assert property (p_pullup) else $error("reset pin pullup off");
    property p_req; (FUNC_SEL_O == FUNC_RESET && !SHARED_PIN_I)[*3] |-> EXT_RESET_REQ_O;
    endproperty
    a_req: assert property (p_req) else $error("low reset pin ignored");
    property p_irq;
        IRQ_IN_O == BRANCH_INT_PIN_LEVEL_O && (FUNC_SEL_O == FUNC_INTERRUPT || IRQ_IN_O);
    endproperty
    a_irq: assert property (p_irq) else $error("irq routing wrong");
    property p_ext_timer_clock_in; (FUNC_SEL_O == FUNC_TIMER_CLK && SHARED_PIN_I)[*3] |-> EXT_TIMER_CLOCK_IN_O;
    endproperty
    a_ext_timer_clock_in: assert property (p_ext_timer_clock_in) else $error("timer clock not routed");
    property p_keep; (OTHER_RESET_I || FORCE_RESET_I) && !POR_I |=> $stable(FUNC_SEL_O);
    endproperty
    a_keep: assert property (p_keep) else $error("function lost on reset");
    property p_por; POR_I |=> FUNC_SEL_O == FUNC_PORT && MODE_SELECT_PHASE_O; endproperty
    a_por: assert property (p_por) else $error("power-on state wrong");
    property p_en; any_rst |=> DEBUG_PIN_ENABLE_O; endproperty
    a_en: assert property (p_en) else $error("enable not set by reset");
    property p_norx; (!DEBUG_PIN_ENABLE_O)[*2] |-> !DBG_RX_VALID_O; endproperty
    a_norx: assert property (p_norx) else $error("rx while disabled");
    property p_speed; (DEBUG_PIN_ENABLE_O && hi_drv) ##1 DEBUG_PIN_ENABLE_O |-> !hi_drv;
    endproperty
    a_speed: assert property (p_speed) else $error("speedup too long");
endmodule // shared_pin_mode_select_monitor

bind shared_pin_mode_select shared_pin_mode_select_monitor mon (.*);

/* verification/debug_host_model.sv */
// debug host model on the pseudo open-drain debug pin
module debug_host_model (
    input  wire logic clk_i,
    input  wire logic send_i,
    input  wire logic bit_i,
    input  wire logic force_low_i,
    input  wire logic tick_i,
    input  wire logic dev_oe_i,
    input  wire logic dev_pin_i,
    input  wire logic dev_pull_i,
    output logic      line_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0] cnt = 5'h00;
    logic       b = 1'b0;
    logic       last = 1'b1;
    // short low for a one, low past the sample point for a zero
    wire host_low = force_low_i | (cnt > (b ? 5'h1a : 5'h06));
    always_comb begin
        if (host_low) line_o = 1'b0;
        else if (dev_oe_i) line_o = dev_pin_i;
        else if (dev_pull_i) line_o = 1'b1;
        else line_o = ~last;
    end
    always_ff @(posedge clk_i) begin
        last <= line_o;
        b <= send_i ? bit_i : b;
        cnt <= send_i ? 5'h1e : (cnt != 5'h00 && tick_i ? cnt - 5'h01 : cnt);
    end
endmodule // debug_host_model

/* verification/shared_pin_mode_select_tb_top.sv */
// testbench for the shared pin mode select block
module shared_pin_mode_select_tb_top
    import pin_mode_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, rst = 1, por = 0, frc = 0, oth = 0, we = 0, clr = 0, p4 = 0;
    logic txa = 0, txb = 0, sp = 1, snd = 0, sbit = 0, hlow = 0, tick = 1;
    logic bo, boe, bpu, soe, spu, req, irq, br, tc, p5, en, mode, ph, rxb, rxv, line;
    logic [1:0] fs = FUNC_PORT, fsel;
    int failures = 0, tests_run = 0, n, div = 1;
    int ks[3] = '{1, 0, 2};
    shared_pin_mode_select dut (.REF_CLK_I(clk), .RST_I(rst), .POR_I(por),
        .FORCE_RESET_I(frc), .OTHER_RESET_I(oth), .FUNC_SEL_I(fs), .FUNC_SEL_WE_I(we),
        .DEBUG_PIN_ENABLE_CLR_I(clr), .PORT_A_BIT4_OUT_I(p4), .DBG_TICK_I(tick),
        .DBG_TX_ACTIVE_I(txa), .DBG_TX_BIT_I(txb), .SHARED_PIN_I(sp),
        .BACKGROUND_DEBUG_PIN_I(line), .BACKGROUND_DEBUG_PIN_O(bo),
        .BACKGROUND_DEBUG_PIN_OE_O(boe), .BACKGROUND_DEBUG_PULLUP_O(bpu),
        .SHARED_PIN_OE_O(soe), .SHARED_PIN_PULLUP_O(spu), .EXT_RESET_REQ_O(req),
        .IRQ_IN_O(irq), .BRANCH_INT_PIN_LEVEL_O(br), .EXT_TIMER_CLOCK_IN_O(tc),
        .PORT_A_BIT5_INPUT_O(p5), .FUNC_SEL_O(fsel), .DEBUG_PIN_ENABLE_O(en),
        .MODE_O(mode), .MODE_SELECT_PHASE_O(ph), .DBG_RX_BIT_O(rxb), .DBG_RX_VALID_O(rxv));
    debug_host_model host (.clk_i(clk), .send_i(snd), .bit_i(sbit), .force_low_i(hlow),
        .tick_i(tick), .dev_oe_i(boe), .dev_pin_i(bo), .dev_pull_i(bpu), .line_o(line));
    initial forever #5 clk = ~clk;
    // slow debug clock: a tick on every other edge when div is two
    initial forever begin
        cyc();
        tick = (div == 1) || !tick;
    end
    // inputs move 1 ns after the edge so sampling never races
    task automatic cyc(int k = 1);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic chk(string nm, logic [1:0] seen, logic [1:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic pulse_rst(int k, logic low);
        hlow = low;
        {por, frc, oth} = 3'h1 << k;
        // a function write during reset must be refused
        fs = FUNC_INTERRUPT;
        we = 1;
        cyc(2);
        {por, frc, oth} = 3'h0;
        we = 0;
        cyc(4);
        hlow = 0;
        cyc(34);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #20us;
        failures++;
        give_verdict();
    end
    initial begin
        cyc(16);
        rst = 0;
        cyc(4);
        chk("fsel", fsel, FUNC_PORT);
        chk("enable", en, 1'b1);
        chk("mode", mode, MODE_RUN);
        chk("phase", ph, 1'b0);
        $display("test power-up done");
        for (int f = 0; f < 4; f++) begin
            for (int p = 1; p >= 0; p--) begin
                fs = f[1:0];
                we = 1;
                sp = p[0];
                cyc();
                we = 0;
                cyc(3);
                chk("fsel", fsel, f[1:0]);
                chk("irq", {irq, br}, f == 1 ? {2{p[0]}} : 2'h3);
                chk("ext_timer_clock_in", tc, f == 2 && p[0]);
                chk("port", {soe, p5}, f == 0 && p[0]);
                chk("req", {spu, req}, {f == 3, f == 3 && !p[0]});
            end
        end
        // pin reset ends with mode select low: still user mode
        hlow = 1;
        cyc(4);
        sp = 1;
        cyc(4);
        hlow = 0;
        cyc(34);
        chk("mode", mode, MODE_RUN);
        $display("test functions done");
        foreach (ks[i]) begin
            pulse_rst(ks[i], 1'b1);
            chk("mode", mode, ks[i] == 0 ? MODE_RUN : MODE_BACKGROUND);
            chk("fsel", fsel, ks[i] == 2 ? FUNC_PORT : FUNC_RESET);
        end
        pulse_rst(2, 1'b0);
        chk("mode", mode, MODE_RUN);
        $display("test resets done");
        for (int b = 0; b < 4; b++) begin
            div = 1 + b / 2;
            sbit = b[0];
            snd = 1;
            cyc();
            snd = 0;
            n = 0;
            while (rxv !== 1'b1 && n < 60) begin
                cyc();
                n++;
            end
            chk("rxbit", rxb, b[0]);
            n = n - BIT_TIME_CYCLES * div;
            chk("rxtime", n >= 0 && n <= 8, 1'b1);
            cyc(30);
        end
        div = 1;
        clr = 1;
        p4 = 1;
        cyc();
        clr = 0;
        cyc();
        chk("enable", en, 1'b0);
        chk("portout", {boe, bo}, 2'h3);
        chk("pullup", bpu, 1'b0);
        p4 = 0;
        cyc();
        chk("portout", {boe, bo}, 2'h2);
        snd = 1;
        cyc();
        snd = 0;
        n = 0;
        repeat (40) begin
            cyc();
            if (rxv !== 1'b0) n++;
        end
        chk("norx", n == 0, 1'b1);
        $display("test debug rx done");
        pulse_rst(0, 1'b0);
        chk("enable", en, 1'b1);
        chk("pullup", bpu, 1'b1);
        chk("idle", line, 1'b1);
        txa = 1;
        cyc();
        chk("tx0", {boe, bo}, 2'h2);
        txb = 1;
        n = 0;
        repeat (4) begin
            cyc();
            if (boe === 1'b1 && bo === 1'b1) n++;
        end
        chk("speedup", n == 1, 1'b1);
        txa = 0;
        $display("test debug tx done");
        give_verdict();
    end
endmodule // shared_pin_mode_select_tb_top
